// [hdl/hs_pkg.sv]
// Purpose: shared constants and types for the gate/flag handshake link
// Assumes: one clock for both ends, synchronous active-high reset
// Notes: control word bits select the handshake modes
`default_nettype none
package hs_pkg;
    localparam int NUM_SLOTS = 8;
    localparam int SLOT_W = 3;
    localparam int WORD_W = 16;
    localparam int DATA_W = 12;
    // control word field positions
    localparam int TME_BIT = 4;
    localparam int SYE_BIT = 5;
    localparam int DTE_BIT = 6;
    localparam int ISL_BIT = 7;
    localparam int IEN_BIT = 8;
    localparam int TOP_BIT = 15;
    localparam logic [2:0] UNUSED_RET = 3'h0;
    // controller register port
    localparam int ADDR_W = 4;
    localparam int RDATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CMD = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] REG_RETURN = 4'h2;
    localparam logic [ADDR_W-1:0] REG_CAPABLE = 4'h3;
    localparam int CMD_SLOT_LSB = 16;
    localparam int CMD_CTRL_BIT = 19;
    localparam int CMD_GATE_BIT = 20;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_REFUSED_BIT = 1;
    localparam int ST_TME_BIT = 2;
    localparam int ST_IEN_BIT = 3;
    localparam int ST_FLAG_BIT = 4;
    localparam logic [NUM_SLOTS-1:0] CAPABLE_RST = 8'h00;
    // cycles an ungated read waits for return data through the device synchronisers
    localparam logic [3:0] READ_SETTLE_CYCLES = 4'h5;
    typedef enum {H_IDLE, H_GATE, H_RELEASE, H_SETTLE} host_state_e;
endpackage : hs_pkg
`default_nettype wire

// [hdl/hs_link_if.sv]
// Purpose: gate/flag link between the controller end and the device end
// Assumes: both ends run on the same clock; the bench connects them
// Notes: controller_flag_busy high means the common flag line is low (busy)
`default_nettype none
interface hs_link_if;
    import hs_pkg::*;
    logic controller_gate;
    logic [WORD_W-1:0] out_word;
    logic word_is_control;
    logic [SLOT_W-1:0] slot_addr;
    logic controller_flag_busy;
    logic [WORD_W-1:0] return_word;
    modport host (
        output controller_gate,
        output out_word,
        output word_is_control,
        output slot_addr,
        input controller_flag_busy,
        input return_word
    );
    modport device (
        input controller_gate,
        input out_word,
        input word_is_control,
        input slot_addr,
        output controller_flag_busy,
        output return_word
    );
endinterface : hs_link_if
`default_nettype wire

// [hdl/handshake_device.sv]
// Purpose: device end: strobe, flag return, common timing flag, return word
// Assumes: card pulls, card return data, request lines and external flag are async
// Notes: active-high internally; a high pull means that source holds the flag line low
//
// Added by the designer: the register offsets and the strobed register port.
`default_nettype none
module handshake_device
    import hs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    hs_link_if.device link,
    input wire logic [NUM_SLOTS-1:0] card_flag_pull_i,
    input wire logic [NUM_SLOTS-1:0] card_input_request_i,
    input wire logic [DATA_W-1:0] card_return_data_i,
    input wire logic external_flag_i,
    input wire logic arm_jumper_option_i,
    output logic data_strobe_o,
    output logic external_gate_o,
    output logic [DATA_W-1:0] card_word_o,
    output logic [SLOT_W-1:0] card_slot_o,
    output logic timing_mode_enable_o,
    output logic system_output_enable_o,
    output logic transfer_sync_enable_o,
    output logic input_select_o,
    output logic interrupt_arm_enable_o
);
    typedef struct packed {
        logic gate_s1;
        logic gate_s2;
        logic gate_prev;
        logic [NUM_SLOTS-1:0] pull_s1;
        logic [NUM_SLOTS-1:0] pull_s2;
        logic ext_s1;
        logic ext_s2;
        logic jmp_s1;
        logic jmp_s2;
        logic [NUM_SLOTS-1:0] irq_s1;
        logic [NUM_SLOTS-1:0] irq_s2;
        logic [DATA_W-1:0] card_s1;
        logic [DATA_W-1:0] card_s2;
        logic strobe;
        logic ctf_ff;
        logic flag_busy;
        logic timing_mode_enable;
        logic system_output_enable;
        logic transfer_sync_enable;
        logic input_select;
        logic interrupt_arm_enable;
        logic [DATA_W-1:0] card_word;
        logic [SLOT_W-1:0] card_slot;
        logic [NUM_SLOTS-1:0] armed;
        logic [NUM_SLOTS-1:0] seen;
        logic [WORD_W-1:0] ret;
    } dev_state_s;

    dev_state_s st_ff;
    dev_state_s nxt_st;
    logic [NUM_SLOTS-1:0] allowed_pull;
    logic gate_rise;
    logic gate_fall;
    logic ctf_busy;
    logic [NUM_SLOTS-1:0] slot_hit;

    function automatic logic [NUM_SLOTS-1:0] slot_decode(input logic [SLOT_W-1:0] slot);
        logic [NUM_SLOTS-1:0] onehot;
        onehot = '0;
        onehot[slot] = 1'b1;
        return onehot;
    endfunction : slot_decode

    // a slot counts toward the flag only once addressed and strobed, or when the
    // jumper lets the arm bit enable it early
    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++)
        begin : g_pull
            assign allowed_pull[gi] = st_ff.pull_s2[gi]
                & (st_ff.armed[gi] | (st_ff.jmp_s2 & st_ff.interrupt_arm_enable));
        end
    endgenerate

    assign gate_rise = st_ff.gate_s2 & ~st_ff.gate_prev;
    assign gate_fall = ~st_ff.gate_s2 & st_ff.gate_prev;
    assign slot_hit = slot_decode(link.slot_addr);
    // any single source holds the line busy; the external flag joins the same path
    assign ctf_busy = st_ff.ctf_ff | (|allowed_pull) | st_ff.ext_s2;

    always_comb
    begin
        nxt_st = st_ff;
        // only the second stage of each synchroniser is read by logic
        nxt_st.gate_s1 = link.controller_gate;
        nxt_st.gate_s2 = st_ff.gate_s1;
        nxt_st.gate_prev = st_ff.gate_s2;
        nxt_st.pull_s1 = card_flag_pull_i;
        nxt_st.pull_s2 = st_ff.pull_s1;
        nxt_st.ext_s1 = external_flag_i;
        nxt_st.ext_s2 = st_ff.ext_s1;
        // the strap is a pin like the others, so it is synchronised as well
        nxt_st.jmp_s1 = arm_jumper_option_i;
        nxt_st.jmp_s2 = st_ff.jmp_s1;
        nxt_st.irq_s1 = card_input_request_i;
        nxt_st.irq_s2 = st_ff.irq_s1;
        nxt_st.card_s1 = card_return_data_i;
        nxt_st.card_s2 = st_ff.card_s1;

        if (gate_rise)
        begin
            nxt_st.strobe = 1'b1;
            if (link.word_is_control)
            begin
                nxt_st.timing_mode_enable = link.out_word[TME_BIT];
                nxt_st.system_output_enable = link.out_word[SYE_BIT];
                nxt_st.transfer_sync_enable = link.out_word[DTE_BIT];
                nxt_st.input_select = link.out_word[ISL_BIT];
                nxt_st.interrupt_arm_enable = link.out_word[IEN_BIT];
                // arming a control word keeps the flip-flop idle for the interrupt sequence
                if (!link.out_word[IEN_BIT])
                begin
                    nxt_st.ctf_ff = 1'b1;
                end
                else
                begin
                    nxt_st.ctf_ff = 1'b0;
                end
            end
            else
            begin
                // card data held until the next gated card write to any slot
                nxt_st.card_word = link.out_word[DATA_W-1:0];
                nxt_st.card_slot = link.slot_addr;
                nxt_st.armed = st_ff.armed | slot_hit;
            end
        end
        else if (gate_fall)
        begin
            nxt_st.strobe = 1'b0;
            nxt_st.ctf_ff = 1'b0;
        end

        // a slot that pulled and then let go has timed out and must be strobed again
        for (int i = 0; i < NUM_SLOTS; i++)
        begin
            if (allowed_pull[i])
            begin
                nxt_st.seen[i] = 1'b1;
            end
            else if (st_ff.seen[i] && !st_ff.pull_s2[i])
            begin
                nxt_st.seen[i] = 1'b0;
                if (!(gate_rise && !link.word_is_control && slot_hit[i]))
                begin
                    nxt_st.armed[i] = 1'b0;
                end
            end
        end

        if (st_ff.timing_mode_enable)
        begin
            nxt_st.flag_busy = ctf_busy;
        end
        else
        begin
            nxt_st.flag_busy = st_ff.strobe;
        end

        if (st_ff.input_select)
        begin
            nxt_st.ret[DATA_W-1:0] = st_ff.card_s2;
            nxt_st.ret[TOP_BIT] = |(st_ff.irq_s2 & slot_hit);
        end
        else
        begin
            nxt_st.ret[DATA_W-1:0] = link.out_word[DATA_W-1:0];
            nxt_st.ret[TOP_BIT] = link.out_word[TOP_BIT];
        end
        nxt_st.ret[TOP_BIT-1:DATA_W] = UNUSED_RET;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign link.controller_flag_busy = st_ff.flag_busy;
    assign link.return_word = st_ff.ret;
    assign data_strobe_o = st_ff.strobe;
    // the far device only sees a gate while the extended handshake is in force
    assign external_gate_o = st_ff.strobe & st_ff.timing_mode_enable & st_ff.transfer_sync_enable;
    assign card_word_o = st_ff.card_word;
    assign card_slot_o = st_ff.card_slot;
    assign timing_mode_enable_o = st_ff.timing_mode_enable;
    assign system_output_enable_o = st_ff.system_output_enable;
    assign transfer_sync_enable_o = st_ff.transfer_sync_enable;
    assign input_select_o = st_ff.input_select;
    assign interrupt_arm_enable_o = st_ff.interrupt_arm_enable;
endmodule : handshake_device
`default_nettype wire

// [hdl/handshake_host.sv]
// Purpose: controller end: runs gated transfers and ungated reads on the link
// Assumes: software uses the register port; device on the same clock
// Notes: a gated card write in timing mode is refused unless the slot is marked capable
`default_nettype none
module handshake_host
    import hs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    hs_link_if.host link,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [RDATA_W-1:0] reg_wdata_i,
    input wire logic reg_write_i,
    input wire logic reg_read_i,
    output logic [RDATA_W-1:0] reg_rdata_o
);
    typedef struct packed {
        host_state_e state;
        logic [3:0] count;
        logic gate;
        logic [WORD_W-1:0] out_word;
        logic [SLOT_W-1:0] slot;
        logic is_ctrl;
        logic timing_mode_enable;
        logic interrupt_arm_enable;
        logic [NUM_SLOTS-1:0] capable;
        logic refused;
        logic [WORD_W-1:0] ret;
        logic [RDATA_W-1:0] rdata;
    } host_state_s;

    host_state_s st_ff;
    host_state_s nxt_st;
    logic cmd_wr;
    logic [SLOT_W-1:0] cmd_slot;
    logic cmd_ctrl;

    assign cmd_wr = reg_write_i && (reg_addr_i == REG_CMD);
    assign cmd_slot = reg_wdata_i[CMD_SLOT_LSB +: SLOT_W];
    assign cmd_ctrl = reg_wdata_i[CMD_CTRL_BIT];

    always_comb
    begin
        nxt_st = st_ff;
        if (reg_write_i && reg_addr_i == REG_CAPABLE)
        begin
            nxt_st.capable = reg_wdata_i[NUM_SLOTS-1:0];
        end
        case (st_ff.state)
            H_IDLE:
            begin
                // commands while a transfer runs are dropped, seen only as busy
                if (cmd_wr)
                begin
                    nxt_st.refused = 1'b0;
                    nxt_st.out_word = reg_wdata_i[WORD_W-1:0];
                    nxt_st.slot = cmd_slot;
                    nxt_st.is_ctrl = cmd_ctrl;
                    if (!reg_wdata_i[CMD_GATE_BIT])
                    begin
                        nxt_st.state = H_SETTLE;
                        nxt_st.count = READ_SETTLE_CYCLES;
                    end
                    else if (st_ff.timing_mode_enable && !cmd_ctrl && !st_ff.capable[cmd_slot])
                    begin
                        // no flag would ever come back; gating would hang the link
                        nxt_st.refused = 1'b1;
                    end
                    else
                    begin
                        nxt_st.state = H_GATE;
                        nxt_st.gate = 1'b1;
                    end
                end
            end
            H_GATE:
            begin
                if (link.controller_flag_busy)
                begin
                    nxt_st.gate = 1'b0;
                    nxt_st.state = H_RELEASE;
                end
            end
            H_RELEASE:
            begin
                // the flag held low means the device is still busy
                if (!link.controller_flag_busy)
                begin
                    nxt_st.state = H_IDLE;
                    nxt_st.ret = link.return_word;
                    if (st_ff.is_ctrl)
                    begin
                        nxt_st.timing_mode_enable = st_ff.out_word[TME_BIT];
                        nxt_st.interrupt_arm_enable = st_ff.out_word[IEN_BIT];
                    end
                end
            end
            H_SETTLE:
            begin
                if (st_ff.count == 4'h0)
                begin
                    nxt_st.ret = link.return_word;
                    nxt_st.state = H_IDLE;
                end
                else
                begin
                    nxt_st.count = st_ff.count - 4'h1;
                end
            end
            default:
            begin
                nxt_st.state = H_IDLE;
                nxt_st.gate = 1'b0;
            end
        endcase

        nxt_st.rdata = '0;
        if (reg_read_i)
        begin
            case (reg_addr_i)
                REG_STATUS:
                begin
                    nxt_st.rdata[ST_BUSY_BIT] = st_ff.state != H_IDLE;
                    nxt_st.rdata[ST_REFUSED_BIT] = st_ff.refused;
                    nxt_st.rdata[ST_TME_BIT] = st_ff.timing_mode_enable;
                    nxt_st.rdata[ST_IEN_BIT] = st_ff.interrupt_arm_enable;
                    nxt_st.rdata[ST_FLAG_BIT] = link.controller_flag_busy;
                end
                REG_RETURN: nxt_st.rdata[WORD_W-1:0] = st_ff.ret;
                REG_CAPABLE: nxt_st.rdata[NUM_SLOTS-1:0] = st_ff.capable;
                default: nxt_st.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            st_ff <= '{state: H_IDLE, capable: CAPABLE_RST, default: '0};
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign link.controller_gate = st_ff.gate;
    assign link.out_word = st_ff.out_word;
    assign link.word_is_control = st_ff.is_ctrl;
    assign link.slot_addr = st_ff.slot;
    assign reg_rdata_o = st_ff.rdata;
endmodule : handshake_host
`default_nettype wire

// [dv/hs_link_checker.sv]
// Purpose: assertions on the gate/flag link between the two ends
// Assumes: one clock, synchronous active-high reset
// Notes: modes are tracked from gated control words seen on the link
`default_nettype none
module hs_link_checker
    import hs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic controller_gate,
    input wire logic [WORD_W-1:0] out_word,
    input wire logic word_is_control,
    input wire logic [SLOT_W-1:0] slot_addr,
    input wire logic controller_flag_busy,
    input wire logic [WORD_W-1:0] return_word
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);
    logic tme_ff;
    logic isl_ff;
    logic quiet;
    // taken at gate rise, ahead of the device; isl_ff is only used once the link is quiet, tme_ff at the gate edges
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            tme_ff <= 1'h0;
            isl_ff <= 1'h0;
        end
        else if ($rose(controller_gate) && word_is_control)
        begin
            tme_ff <= out_word[TME_BIT];
            isl_ff <= out_word[ISL_BIT];
        end
    end
    assign quiet = !controller_gate && !controller_flag_busy && !isl_ff;
    sequence lead_edge_s;
        !controller_flag_busy [*4] ##1 controller_flag_busy;
    endsequence
    sequence trail_edge_s;
        controller_flag_busy [*4] ##1 !controller_flag_busy;
    endsequence
    AST_RET_LOW: assert property (quiet && $stable(out_word) |->
        return_word[DATA_W-1:0] == out_word[DATA_W-1:0]) else $error("low return bits differ");
    AST_RET_UNUSED: assert property (return_word[14:12] == UNUSED_RET)
        else $error("unused return bits driven");
    AST_RET_TOP: assert property (quiet && $stable(out_word) |->
        return_word[TOP_BIT] == out_word[TOP_BIT]) else $error("top return bit differs");
    AST_AUTO_LEAD: assert property ($rose(controller_gate) && !tme_ff |-> lead_edge_s)
        else $error("automatic flag did not rise on time");
    AST_AUTO_TRAIL: assert property ($fell(controller_gate) && !tme_ff |-> trail_edge_s)
        else $error("automatic flag did not fall on time");
    AST_HOST_RELEASE: assert property (controller_gate && controller_flag_busy |=>
        !controller_gate) else $error("gate held after flag");
    AST_HOST_WAIT: assert property ($rose(controller_gate) |->
        !$past(controller_flag_busy)) else $error("gate raised while busy");
    AST_FLIPFLOP_SET: assert property ($rose(controller_gate) && word_is_control
        && !out_word[IEN_BIT] |-> ##4 controller_flag_busy) else $error("control gate gave no flag");
    AST_WORD_HOLD: assert property (controller_gate && $past(controller_gate) |->
        $stable(out_word) && $stable(slot_addr) && $stable(word_is_control))
        else $error("word changed under gate");
endmodule : hs_link_checker
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for host and device ends joined by the link
// Assumes: one 10 MHz clock, reset held 5 cycles
// Notes: card pulls and the external flag stand in for the cards
`default_nettype none
module tb_top
    import hs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk_i = 1'h0;
    logic reset_i = 1'h1;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [RDATA_W-1:0] reg_wdata = 32'h0;
    logic reg_write = 1'h0;
    logic reg_read = 1'h0;
    logic [RDATA_W-1:0] reg_rdata;
    logic [NUM_SLOTS-1:0] pull = 8'h0;
    logic [NUM_SLOTS-1:0] req = 8'h0;
    logic [DATA_W-1:0] card_data = 12'h0;
    logic ext_flag = 1'h0;
    logic jumper = 1'h0;
    logic strobe;
    logic ext_gate;
    logic [DATA_W-1:0] card_word;
    logic [SLOT_W-1:0] card_slot;
    wire [4:0] modes;
    logic [RDATA_W-1:0] rd;
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    hs_link_if link();
    handshake_host handshake_host_i (.core_clk_i, .reset_i, .link(link), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_write_i(reg_write), .reg_read_i(reg_read),
        .reg_rdata_o(reg_rdata));
    handshake_device handshake_device_i (.core_clk_i, .reset_i, .link(link),
        .card_flag_pull_i(pull), .card_input_request_i(req), .card_return_data_i(card_data),
        .external_flag_i(ext_flag), .arm_jumper_option_i(jumper), .data_strobe_o(strobe),
        .external_gate_o(ext_gate), .card_word_o(card_word), .card_slot_o(card_slot),
        .timing_mode_enable_o(modes[0]), .system_output_enable_o(modes[1]),
        .transfer_sync_enable_o(modes[2]), .input_select_o(modes[3]),
        .interrupt_arm_enable_o(modes[4]));
    hs_link_checker hs_link_checker_i (.core_clk_i, .reset_i,
        .controller_gate(link.controller_gate), .out_word(link.out_word),
        .word_is_control(link.word_is_control), .slot_addr(link.slot_addr),
        .controller_flag_busy(link.controller_flag_busy), .return_word(link.return_word));
    always #50 core_clk_i = ~core_clk_i;
    task automatic check(input logic [RDATA_W-1:0] seen, input logic [RDATA_W-1:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [RDATA_W-1:0] d);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge core_clk_i);
        reg_write <= 1'h0;
    endtask : reg_wr
    // read data stand only in the cycle after the strobe, so sample just inside it
    task automatic reg_rd(input logic [ADDR_W-1:0] a);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge core_clk_i);
        reg_read <= 1'h0;
        #1;
        rd = reg_rdata;
    endtask : reg_rd
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [RDATA_W-1:0] exp);
        reg_rd(a);
        check(rd, exp);
    endtask : rd_chk
    task automatic cmd(input logic [15:0] w, input logic [2:0] s, input logic c, input logic g);
        reg_wr(REG_CMD, {11'h0, g, c, s, w});
    endtask : cmd
    task automatic wait_idle();
        int n;
        n = 0;
        rd = 32'h1;
        while (rd[ST_BUSY_BIT] !== 1'h0 && n < 100)
        begin
            reg_rd(REG_STATUS);
            n++;
        end
        check(32'(rd[ST_BUSY_BIT]), 32'h0);
    endtask : wait_idle
    task automatic wait_strobe();
        int n;
        n = 0;
        // look just after the edge so the strobe launched there has settled
        while (strobe !== 1'h1 && n < 20)
        begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        check(32'(strobe), 32'h1);
    endtask : wait_strobe
    always @(posedge core_clk_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            error_cnt++;
            $display("mismatch at %0t: run hung", $time);
            finish_test();
        end
    end
    initial
    begin
        repeat (5) @(posedge core_clk_i);
        reset_i <= 1'h0;
        rd_chk(REG_STATUS, 32'h0);
        rd_chk(REG_RETURN, 32'h0);
        rd_chk(4'h7, 32'h0);
        rd_chk(REG_CAPABLE, 32'h0);
        reg_wr(REG_CAPABLE, 32'h2);
        rd_chk(REG_CAPABLE, 32'h2);
        $display("test registers done");
        cmd(16'hfabc, 3'h2, 1'h0, 1'h1);
        wait_idle();
        rd_chk(REG_RETURN, 32'h8abc);
        check(32'({card_slot, card_word}), 32'h2abc);
        cmd(16'h0123, 3'h2, 1'h0, 1'h0);
        wait_idle();
        rd_chk(REG_RETURN, 32'h0123);
        check(32'({card_slot, card_word}), 32'h2abc);
        $display("test automatic transfer done");
        for (int i = 0; i < 5; i++)
        begin
            cmd(16'(1 << (TME_BIT + i)), 3'h0, 1'h1, 1'h1);
            wait_idle();
            check(32'(modes), 32'(1 << i));
        end
        rd_chk(REG_STATUS, 32'h8);
        $display("test mode bits done");
        card_data <= 12'h5a3;
        req <= 8'h10;
        cmd(16'h0080, 3'h0, 1'h1, 1'h1);
        wait_idle();
        cmd(16'h0000, 3'h4, 1'h0, 1'h0);
        wait_idle();
        rd_chk(REG_RETURN, 32'h85a3);
        cmd(16'h8fff, 3'h3, 1'h0, 1'h0);
        wait_idle();
        rd_chk(REG_RETURN, 32'h05a3);
        $display("test input select done");
        cmd(16'h0050, 3'h0, 1'h1, 1'h1);
        wait_idle();
        pull <= 8'h20;
        repeat (6) @(posedge core_clk_i);
        rd_chk(REG_STATUS, 32'h4);
        pull <= 8'h0;
        cmd(16'h0011, 3'h1, 1'h0, 1'h1);
        wait_strobe();
        check(32'(ext_gate), 32'h1);
        @(posedge core_clk_i);
        pull <= 8'h02;
        ext_flag <= 1'h1;
        repeat (20) @(posedge core_clk_i);
        rd_chk(REG_STATUS, 32'h15);
        ext_flag <= 1'h0;
        repeat (6) @(posedge core_clk_i);
        rd_chk(REG_STATUS, 32'h15);
        pull <= 8'h0;
        wait_idle();
        $display("test timing mode done");
        // slot 3 is not marked capable, so a gate to it would never see a flag
        cmd(16'h0abc, 3'h3, 1'h0, 1'h1);
        rd_chk(REG_STATUS, 32'h6);
        check(32'({card_slot, card_word}), 32'h1011);
        $display("test refusal done");
        jumper <= 1'h1;
        cmd(16'h0110, 3'h0, 1'h1, 1'h1);
        wait_strobe();
        check(32'(ext_gate), 32'h0);
        repeat (8) @(posedge core_clk_i);
        #1;
        check(32'(link.controller_flag_busy), 32'h0);
        @(posedge core_clk_i);
        pull <= 8'h40;
        repeat (8) @(posedge core_clk_i);
        pull <= 8'h0;
        wait_idle();
        rd_chk(REG_STATUS, 32'hc);
        cmd(16'h0000, 3'h0, 1'h1, 1'h1);
        wait_idle();
        check(32'(modes), 32'h0);
        jumper <= 1'h0;
        $display("test arm option done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
